// *** verilog/dfs_status_map.sv ***
// Fieldbus register map of a drive: status words, parameters and command entries
`timescale 1ns/1ps

module dfs_status_map #(
    parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary maker code
    parameter logic [7:0] PRODUCT_CODE = 8'h3C // Arbitrary product code
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic reqValid,
    output logic reqReady,
    input wire dfs_pkg::dfs_req_t req,
    output logic rspValid,
    output dfs_pkg::dfs_rsp_t rsp,
    input wire dfs_pkg::dfs_stat_t stat,
    output logic cmdStrobe,
    output logic [15:0] cmdCode,
    output logic setpointStrobe,
    output logic [15:0] setpoint,
    output logic [15:0] runSrc,
    output logic [15:0] runCh,
    output logic [15:0] loopSrc,
    output logic [15:0] wakeDelaySec,
    output logic [3:0] wakeDelayTenth
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    dfs_pkg::dfs_state_t state_r; // Request/reply state
    dfs_pkg::dfs_state_t state_nxt;
    dfs_pkg::dfs_rsp_t rsp_r; // Captured reply
    dfs_pkg::dfs_rsp_t rsp_nxt;
    logic [15:0] runSrc_r; // Run command source parameter
    logic [15:0] runSrc_nxt;
    logic [15:0] runCh_r; // Communication run channel parameter
    logic [15:0] runCh_nxt;
    logic [15:0] loopSrc_r; // Loop setpoint source parameter
    logic [15:0] loopSrc_nxt;
    logic [15:0] wakeDly_r; // One-decimal delay, raw scaled integer
    logic [15:0] wakeDly_nxt;
    logic cmdStrobe_r; // Accepted run/stop command pulse
    logic cmdStrobe_nxt;
    logic [15:0] cmdCode_r; // Last applied command
    logic [15:0] cmdCode_nxt;
    logic setStrobe_r; // Accepted setpoint pulse
    logic setStrobe_nxt;
    logic [15:0] setpoint_r; // Last applied setpoint
    logic [15:0] setpoint_nxt;
    logic [15:0] wakeSec_r; // Delay in whole units
    logic [15:0] wakeSec_nxt;
    logic [3:0] wakeTenth_r; // Delay tenths digit
    logic [3:0] wakeTenth_nxt;
    logic take; // Request taken this cycle
    logic hit; // Address maps to an entry
    logic isRo; // Entry is read-only
    logic isWo; // Entry is write-only
    logic rangeOk; // Written value within limits
    logic [15:0] rdWord; // Word returned on a read
    logic wrOk; // Write accepted
    logic runEnabled; // Link may start and stop the drive
    logic loopEnabled; // Link setpoint is in use
    logic okRunSrc;
    logic okRunCh;
    logic okLoopSrc;
    logic okWake;
    logic okCmd;
    logic okSet;
    logic [15:0] divQuot;
    logic [3:0] divRem;
    logic [3:0] outBits; // Local output pins, in map order

    // ------------------------------------------------------------
    // Range checkers, one per writable entry
    // ------------------------------------------------------------
    dfs_range_chk #(.IS_SIGNED(1'b0), .LO(dfs_pkg::RANGE_ZERO), .HI(dfs_pkg::RUN_SRC_MAX))
        uRunSrc (.val(req.data), .ok(okRunSrc));
    dfs_range_chk #(.IS_SIGNED(1'b0), .LO(dfs_pkg::RANGE_ZERO), .HI(dfs_pkg::RUN_CH_MAX))
        uRunCh (.val(req.data), .ok(okRunCh));
    dfs_range_chk #(.IS_SIGNED(1'b0), .LO(dfs_pkg::RANGE_ZERO), .HI(dfs_pkg::LOOP_SRC_MAX))
        uLoopSrc (.val(req.data), .ok(okLoopSrc));
    dfs_range_chk #(.IS_SIGNED(1'b0), .LO(dfs_pkg::RANGE_ZERO), .HI(dfs_pkg::WAKE_DLY_MAX))
        uWake (.val(req.data), .ok(okWake));
    dfs_range_chk #(.IS_SIGNED(1'b0), .LO(dfs_pkg::CMD_MIN), .HI(dfs_pkg::CMD_MAX))
        uCmd (.val(req.data), .ok(okCmd));
    dfs_range_chk #(.IS_SIGNED(1'b1), .LO(dfs_pkg::SET_MIN), .HI(dfs_pkg::SET_MAX))
        uSet (.val(req.data), .ok(okSet));

    // ------------------------------------------------------------
    // Scaled delay back to engineering units
    // ------------------------------------------------------------
    dfs_div10 uDiv (.val(wakeDly_r), .quot(divQuot), .rem(divRem));

    // ------------------------------------------------------------
    // Address decode: entry kind, read word and range verdict
    // ------------------------------------------------------------
    always_comb begin
        hit = 1'b0;
        isRo = 1'b0;
        isWo = 1'b0;
        rangeOk = 1'b0;
        rdWord = 16'h0000;
        outBits = {stat.relayOutB, stat.relayOutA, stat.fastPulseOut, stat.openCollectorOut};
        if (req.addr == dfs_pkg::ADDR_OUT_STATE) begin
            // Four output bits, upper bits read zero
            hit = 1'b1;
            isRo = 1'b1;
            rdWord = 16'(outBits);
        end else if (req.addr == dfs_pkg::ADDR_ANALOG_1) begin
            hit = 1'b1;
            isRo = 1'b1;
            rdWord = stat.analog1;
        end else if (req.addr == dfs_pkg::ADDR_ANALOG_2) begin
            hit = 1'b1;
            isRo = 1'b1;
            rdWord = stat.analog2;
        end else if (req.addr == dfs_pkg::ADDR_ANALOG_3) begin
            // Signed input passed through as two's complement
            hit = 1'b1;
            isRo = 1'b1;
            rdWord = stat.analog3;
        end else if (req.addr == dfs_pkg::ADDR_ANALOG_4) begin
            hit = 1'b1;
            isRo = 1'b1;
            rdWord = stat.analog4;
        end else if (req.addr == dfs_pkg::ADDR_PULSE_1) begin
            hit = 1'b1;
            isRo = 1'b1;
            rdWord = stat.pulse1Freq;
        end else if (req.addr == dfs_pkg::ADDR_PULSE_2) begin
            hit = 1'b1;
            isRo = 1'b1;
            rdWord = stat.pulse2Freq;
        end else if (req.addr == dfs_pkg::ADDR_STEP_IDX) begin
            hit = 1'b1;
            isRo = 1'b1;
            rdWord = stat.stepIdx;
        end else if (req.addr == dfs_pkg::ADDR_LENGTH) begin
            hit = 1'b1;
            isRo = 1'b1;
            rdWord = stat.lengthVal;
        end else if (req.addr == dfs_pkg::ADDR_COUNT) begin
            hit = 1'b1;
            isRo = 1'b1;
            rdWord = stat.countVal;
        end else if (req.addr == dfs_pkg::ADDR_TORQUE) begin
            // Signed torque setting, two's complement
            hit = 1'b1;
            isRo = 1'b1;
            rdWord = stat.torqueVal;
        end else if (req.addr == dfs_pkg::ADDR_IDENT) begin
            // Maker in the high byte, product in the low byte
            hit = 1'b1;
            isRo = 1'b1;
            rdWord = {MAKER_CODE, PRODUCT_CODE};
        end else if (req.addr == dfs_pkg::ADDR_FAULT) begin
            hit = 1'b1;
            isRo = 1'b1;
            rdWord = stat.faultCode;
        end else if (req.addr == dfs_pkg::ADDR_RUN_SRC) begin
            hit = 1'b1;
            rdWord = runSrc_r;
            rangeOk = okRunSrc;
        end else if (req.addr == dfs_pkg::ADDR_RUN_CH) begin
            hit = 1'b1;
            rdWord = runCh_r;
            rangeOk = okRunCh;
        end else if (req.addr == dfs_pkg::ADDR_LOOP_SRC) begin
            hit = 1'b1;
            rdWord = loopSrc_r;
            rangeOk = okLoopSrc;
        end else if (req.addr == dfs_pkg::ADDR_WAKE_DLY) begin
            // Read back as the same scaled integer that was written
            hit = 1'b1;
            rdWord = wakeDly_r;
            rangeOk = okWake;
        end else if (req.addr == dfs_pkg::ADDR_COMM_CMD) begin
            hit = 1'b1;
            isWo = 1'b1;
            rangeOk = okCmd;
        end else if (req.addr == dfs_pkg::ADDR_LOOP_SET) begin
            hit = 1'b1;
            isWo = 1'b1;
            rangeOk = okSet;
        end
    end

    // ------------------------------------------------------------
    // Reply builder and request/reply sequencing
    // ------------------------------------------------------------
    always_comb begin
        take = reqValid && (state_r == dfs_pkg::ST_IDLE);
        state_nxt = state_r;
        rsp_nxt = rsp_r;
        wrOk = 1'b0;
        case (state_r)
            dfs_pkg::ST_IDLE: begin
                if (take) begin
                    state_nxt = dfs_pkg::ST_REPLY;
                    rsp_nxt.func = req.func;
                    rsp_nxt.data = 16'h0000;
                    rsp_nxt.exc = 1'b0;
                    rsp_nxt.errCode = 8'h00;
                    if (req.func == dfs_pkg::FC_READ) begin
                        // Write-only entries give no contents back
                        if (!hit || isWo) begin
                            rsp_nxt.exc = 1'b1;
                            rsp_nxt.errCode = dfs_pkg::ERR_BAD_ADDR;
                        end else begin
                            rsp_nxt.data = rdWord;
                        end
                    end else if (req.func == dfs_pkg::FC_WRITE) begin
                        // Single-register write; reply echoes the value
                        if (!hit) begin
                            rsp_nxt.exc = 1'b1;
                            rsp_nxt.errCode = dfs_pkg::ERR_BAD_ADDR;
                        end else if (isRo) begin
                            rsp_nxt.exc = 1'b1;
                            rsp_nxt.errCode = dfs_pkg::ERR_READ_ONLY;
                        end else if (!rangeOk) begin
                            rsp_nxt.exc = 1'b1;
                            rsp_nxt.errCode = dfs_pkg::ERR_RANGE;
                        end else begin
                            wrOk = 1'b1;
                            rsp_nxt.data = req.data;
                        end
                    end else begin
                        // Unsupported function code
                        rsp_nxt.exc = 1'b1;
                        rsp_nxt.errCode = dfs_pkg::ERR_BAD_CMD;
                    end
                    if (rsp_nxt.exc) begin
                        // Exception reply: function code with top bit set
                        rsp_nxt.func = req.func | dfs_pkg::FC_EXC_BIT;
                    end
                end
            end
            dfs_pkg::ST_REPLY: begin
                // Reply stands for one cycle
                state_nxt = dfs_pkg::ST_IDLE;
            end
            default: begin
                state_nxt = dfs_pkg::ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Parameter store and command application
    // ------------------------------------------------------------
    always_comb begin
        runEnabled = (runSrc_r == dfs_pkg::RUN_SRC_COMM)
            && (runCh_r == dfs_pkg::RUN_CH_MODBUS);
        loopEnabled = (loopSrc_r == dfs_pkg::LOOP_SRC_MODBUS);
        runSrc_nxt = runSrc_r;
        runCh_nxt = runCh_r;
        loopSrc_nxt = loopSrc_r;
        wakeDly_nxt = wakeDly_r;
        cmdStrobe_nxt = 1'b0;
        cmdCode_nxt = cmdCode_r;
        setStrobe_nxt = 1'b0;
        setpoint_nxt = setpoint_r;
        // Delay kept as scaled integer, shown as units and tenths
        wakeSec_nxt = divQuot;
        wakeTenth_nxt = divRem;
        if (wrOk) begin
            if (req.addr == dfs_pkg::ADDR_RUN_SRC) begin
                runSrc_nxt = req.data;
            end else if (req.addr == dfs_pkg::ADDR_RUN_CH) begin
                runCh_nxt = req.data;
            end else if (req.addr == dfs_pkg::ADDR_LOOP_SRC) begin
                loopSrc_nxt = req.data;
            end else if (req.addr == dfs_pkg::ADDR_WAKE_DLY) begin
                wakeDly_nxt = req.data;
            end else if (req.addr == dfs_pkg::ADDR_COMM_CMD) begin
                // Command acknowledged but only applied when enabled
                if (runEnabled) begin
                    cmdStrobe_nxt = 1'b1;
                    cmdCode_nxt = req.data;
                end
            end else if (req.addr == dfs_pkg::ADDR_LOOP_SET) begin
                // Setpoint used only with the link as its source
                if (loopEnabled) begin
                    setStrobe_nxt = 1'b1;
                    setpoint_nxt = req.data;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= dfs_pkg::ST_IDLE;
            rsp_r <= '0;
            runSrc_r <= dfs_pkg::PARAM_RESET;
            runCh_r <= dfs_pkg::PARAM_RESET;
            loopSrc_r <= dfs_pkg::PARAM_RESET;
            wakeDly_r <= dfs_pkg::PARAM_RESET;
            cmdStrobe_r <= 1'b0;
            cmdCode_r <= dfs_pkg::PARAM_RESET;
            setStrobe_r <= 1'b0;
            setpoint_r <= dfs_pkg::PARAM_RESET;
            wakeSec_r <= dfs_pkg::PARAM_RESET;
            wakeTenth_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            rsp_r <= rsp_nxt;
            runSrc_r <= runSrc_nxt;
            runCh_r <= runCh_nxt;
            loopSrc_r <= loopSrc_nxt;
            wakeDly_r <= wakeDly_nxt;
            cmdStrobe_r <= cmdStrobe_nxt;
            cmdCode_r <= cmdCode_nxt;
            setStrobe_r <= setStrobe_nxt;
            setpoint_r <= setpoint_nxt;
            wakeSec_r <= wakeSec_nxt;
            wakeTenth_r <= wakeTenth_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reqReady = (state_r == dfs_pkg::ST_IDLE);
    assign rspValid = (state_r == dfs_pkg::ST_REPLY);
    assign rsp = rsp_r;
    assign cmdStrobe = cmdStrobe_r;
    assign cmdCode = cmdCode_r;
    assign setpointStrobe = setStrobe_r;
    assign setpoint = setpoint_r;
    assign runSrc = runSrc_r;
    assign runCh = runCh_r;
    assign loopSrc = loopSrc_r;
    assign wakeDelaySec = wakeSec_r;
    assign wakeDelayTenth = wakeTenth_r;

endmodule

// *** verilog/dfs_pkg.sv ***
// Package with address map, codes, ranges and carrier types of the drive status map
package dfs_pkg;

    // ------------------------------------------------------------
    // Status map addresses
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_OUT_STATE = 16'h300B;
    localparam logic [15:0] ADDR_ANALOG_1 = 16'h300C;
    localparam logic [15:0] ADDR_ANALOG_2 = 16'h300D;
    localparam logic [15:0] ADDR_ANALOG_3 = 16'h300E;
    localparam logic [15:0] ADDR_ANALOG_4 = 16'h300F;
    localparam logic [15:0] ADDR_PULSE_1 = 16'h3010;
    localparam logic [15:0] ADDR_PULSE_2 = 16'h3011;
    localparam logic [15:0] ADDR_STEP_IDX = 16'h3012;
    localparam logic [15:0] ADDR_LENGTH = 16'h3013;
    localparam logic [15:0] ADDR_COUNT = 16'h3014;
    localparam logic [15:0] ADDR_TORQUE = 16'h3015;
    localparam logic [15:0] ADDR_IDENT = 16'h3016;
    localparam logic [15:0] ADDR_FAULT = 16'h5000;

    // ------------------------------------------------------------
    // Writable parameters and write-only command entries
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_RUN_SRC = 16'h0001;
    localparam logic [15:0] ADDR_RUN_CH = 16'h0002;
    localparam logic [15:0] ADDR_WAKE_DLY = 16'h0114;
    localparam logic [15:0] ADDR_LOOP_SRC = 16'h0900;
    localparam logic [15:0] ADDR_COMM_CMD = 16'h2000;
    localparam logic [15:0] ADDR_LOOP_SET = 16'h2002;

    // ------------------------------------------------------------
    // Function and exception codes
    // ------------------------------------------------------------
    localparam logic [7:0] FC_READ = 8'h03;
    localparam logic [7:0] FC_WRITE = 8'h06;
    localparam logic [7:0] FC_EXC_BIT = 8'h80;
    localparam logic [7:0] ERR_BAD_CMD = 8'h01;
    localparam logic [7:0] ERR_BAD_ADDR = 8'h02;
    localparam logic [7:0] ERR_RANGE = 8'h04;
    localparam logic [7:0] ERR_READ_ONLY = 8'h07;

    // ------------------------------------------------------------
    // Enabling selections, ranges and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RUN_SRC_COMM = 16'h0002;
    localparam logic [15:0] RUN_CH_MODBUS = 16'h0000;
    localparam logic [15:0] LOOP_SRC_MODBUS = 16'h0007;
    localparam logic signed [16:0] RUN_SRC_MAX = 17'sh00002;
    localparam logic signed [16:0] RUN_CH_MAX = 17'sh00003;
    localparam logic signed [16:0] LOOP_SRC_MAX = 17'sh00007;
    localparam logic signed [16:0] WAKE_DLY_MAX = 17'sh08CA0;
    localparam logic signed [16:0] CMD_MIN = 17'sh00001;
    localparam logic signed [16:0] CMD_MAX = 17'sh00007;
    localparam logic signed [16:0] SET_MIN = -17'sh003E8;
    localparam logic signed [16:0] SET_MAX = 17'sh003E8;
    localparam logic signed [16:0] RANGE_ZERO = 17'sh00000;
    localparam logic [15:0] PARAM_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Scale of one-decimal parameters: divide by ten by reciprocal
    // ------------------------------------------------------------
    localparam logic [15:0] SCALE_ONE_DEC = 16'h000A;
    localparam logic [35:0] DIV10_MUL = 36'h00000CCCD;
    localparam int DIV10_SHIFT = 19;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REPLY = 2'b01
    } dfs_state_t;

    typedef struct packed {
        logic [7:0] func;
        logic [15:0] addr;
        logic [15:0] data;
    } dfs_req_t;

    typedef struct packed {
        logic [7:0] func;
        logic [15:0] data;
        logic exc;
        logic [7:0] errCode;
    } dfs_rsp_t;

    typedef struct packed {
        logic relayOutB;
        logic relayOutA;
        logic fastPulseOut;
        logic openCollectorOut;
        logic [15:0] analog1;
        logic [15:0] analog2;
        logic [15:0] analog3;
        logic [15:0] analog4;
        logic [15:0] pulse1Freq;
        logic [15:0] pulse2Freq;
        logic [15:0] stepIdx;
        logic [15:0] lengthVal;
        logic [15:0] countVal;
        logic [15:0] torqueVal;
        logic [15:0] faultCode;
    } dfs_stat_t;

endpackage

// *** verilog/dfs_div10.sv ***
// Divide-by-ten unit that turns a scaled integer into whole units and tenths
`timescale 1ns/1ps

module dfs_div10 (
    input wire logic [15:0] val,
    output logic [15:0] quot,
    output logic [3:0] rem
);

    // ------------------------------------------------------------
    // Reciprocal multiply, exact over the whole 16-bit range
    // ------------------------------------------------------------
    logic [35:0] prod; // Product with the reciprocal
    logic [15:0] back; // Quotient scaled back up

    always_comb begin
        prod = {20'h00000, val} * dfs_pkg::DIV10_MUL;
        quot = prod[dfs_pkg::DIV10_SHIFT +: 16];
        back = 16'(quot * dfs_pkg::SCALE_ONE_DEC);
        rem = 4'(val - back);
    end

endmodule

// *** verilog/dfs_range_chk.sv ***
// Range check of a written word against a parameter's permitted limits
`timescale 1ns/1ps

module dfs_range_chk #(
    parameter logic IS_SIGNED = 1'b0,
    parameter logic signed [16:0] LO = 17'sh00000,
    parameter logic signed [16:0] HI = 17'sh00000
) (
    input wire logic [15:0] val,
    output logic ok
);

    // ------------------------------------------------------------
    // Extend by sign or zero, then compare both limits
    // ------------------------------------------------------------
    logic signed [16:0] ext; // Value widened for a signed compare

    always_comb begin
        ext = IS_SIGNED ? {val[15], val} : {1'b0, val};
        ok = (ext >= LO) && (ext <= HI);
    end

endmodule

// *** verif/dfs_status_chk.sv ***
// Checker of reply timing, codes and enables of the drive status map
`timescale 1ns/1ps

module dfs_status_chk #(
    parameter logic [7:0] MAKER_CODE = 8'h5A,
    parameter logic [7:0] PRODUCT_CODE = 8'h3C
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic reqValid,
    input wire logic reqReady,
    input wire dfs_pkg::dfs_req_t req,
    input wire logic rspValid,
    input wire dfs_pkg::dfs_rsp_t rsp,
    input wire dfs_pkg::dfs_stat_t stat,
    input wire logic cmdStrobe,
    input wire logic setpointStrobe,
    input wire logic [15:0] runSrc,
    input wire logic [15:0] runCh,
    input wire logic [15:0] loopSrc,
    input wire logic [15:0] wakeDelaySec
);
    // ------------------------------
    // Decoded requests and checks
    // ------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic rd; // Read taken this edge
    logic wr; // Write taken this edge
    logic [3:0] outBits; // Live output states in word order
    assign rd = reqValid && reqReady && req.func == 8'h03;
    assign wr = reqValid && reqReady && req.func == 8'h06;
    assign outBits = {stat.relayOutB, stat.relayOutA, stat.fastPulseOut, stat.openCollectorOut};
    AST_RSP_NEXT: assert property (reqValid && reqReady |=> rspValid && !reqReady)
        else $error("reply missing after request");
    AST_RSP_PULSE: assert property (rspValid |=> !rspValid && reqReady)
        else $error("reply pulse too long");
    AST_EXC_FORM: assert property (rspValid && rsp.exc |-> rsp.func[7] && rsp.data == 16'h0000)
        else $error("exception reply badly formed");
    AST_RO_WRITE: assert property (wr && req.addr inside {[16'h300B:16'h3016], 16'h5000}
        |=> rsp.exc && rsp.errCode == 8'h07) else $error("read-only write not refused");
    AST_IDENT: assert property (rd && req.addr == 16'h3016
        |=> rsp.data == {MAKER_CODE, PRODUCT_CODE}) else $error("ident word wrong");
    AST_OUT_BITS: assert property (rd && req.addr == 16'h300B
        |=> rsp.data == {12'h000, $past(outBits)}) else $error("output state word wrong");
    AST_CMD_GATE: assert property (cmdStrobe |-> runSrc == 16'h0002 && runCh == 16'h0000)
        else $error("command applied while not enabled");
    AST_SET_GATE: assert property (setpointStrobe |-> loopSrc == 16'h0007)
        else $error("setpoint applied while not enabled");
    AST_RANGE: assert property (wr && req.addr == 16'h0001 && req.data > 16'h0002
        |=> rsp.exc && rsp.errCode == 8'h04) else $error("range write not refused");
    AST_DIV10: assert property (wr && req.addr == 16'h0114 && req.data <= 16'h8CA0
        |-> ##2 wakeDelaySec == $past(req.data, 2) / 16'h000A) else $error("delay not scaled");
    COV_CMD: cover property (cmdStrobe);
    COV_SET: cover property (setpointStrobe);
    COV_EXC: cover property (rspValid && rsp.exc);
endmodule

bind dfs_status_map dfs_status_chk #(.MAKER_CODE(MAKER_CODE), .PRODUCT_CODE(PRODUCT_CODE))
    dfs_status_chk_i (.clk(clk), .rst(rst), .reqValid(reqValid), .reqReady(reqReady),
    .req(req), .rspValid(rspValid), .rsp(rsp), .stat(stat), .cmdStrobe(cmdStrobe),
    .setpointStrobe(setpointStrobe), .runSrc(runSrc), .runCh(runCh), .loopSrc(loopSrc),
    .wakeDelaySec(wakeDelaySec));

// *** verif/dfs_bus_master.sv ***
// Fieldbus master model issuing one request at a time
`timescale 1ns/1ps

module dfs_bus_master (
    input wire logic clk,
    input wire logic reqReady,
    input wire logic rspValid,
    input wire dfs_pkg::dfs_rsp_t rsp,
    output logic reqValid,
    output dfs_pkg::dfs_req_t req
);
    // ------------------------------
    // Idle bus and one transfer
    // ------------------------------
    initial begin
        reqValid = 1'b0;
        req = '0;
    end
    // Holds request until taken, then inverts the released bus
    task automatic xfer(input logic [7:0] f, input logic [15:0] a, d,
        output dfs_pkg::dfs_rsp_t r);
        int n = 0;
        @(posedge clk);
        reqValid <= 1'b1;
        req <= {f, a, d};
        @(negedge clk);
        while (!reqReady && n < 50) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        reqValid <= 1'b0;
        req <= ~req;
        @(negedge clk);
        r = rspValid ? rsp : '1;
    endtask
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the drive status map
`timescale 1ns/1ps

module testbench;
    // ------------------------------
    // Signals, tables and instances
    // ------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reqValid, reqReady, rspValid, cmdStrobe, setpointStrobe;
    dfs_pkg::dfs_req_t req;
    dfs_pkg::dfs_rsp_t rsp, r;
    dfs_pkg::dfs_stat_t stat = '0;
    logic [15:0] cmdCode, setpoint, runSrc, runCh, loopSrc, wakeDelaySec;
    logic [3:0] wakeDelayTenth;
    int bad_count = 0, tests_run = 0;
    int cmdSeen = 0, setSeen = 0;
    logic [15:0] mapAddr [13] = '{16'h300B, 16'h300C, 16'h300D, 16'h300E, 16'h300F, 16'h3010,
        16'h3011, 16'h3012, 16'h3013, 16'h3014, 16'h3015, 16'h3016, 16'h5000};
    logic [15:0] mapData [13] = '{16'h000B, 16'h03E8, 16'h01F4, 16'hFC18, 16'h0123, 16'h1388,
        16'h0456, 16'h000F, 16'hFFFF, 16'h0789, 16'hF448, 16'h5A3C, 16'h0011};
    always #4 clk = ~clk;
    dfs_status_map dfs_status_map_i (.clk(clk), .rst(rst), .reqValid(reqValid),
        .reqReady(reqReady), .req(req), .rspValid(rspValid), .rsp(rsp), .stat(stat),
        .cmdStrobe(cmdStrobe), .cmdCode(cmdCode), .setpointStrobe(setpointStrobe),
        .setpoint(setpoint), .runSrc(runSrc), .runCh(runCh), .loopSrc(loopSrc),
        .wakeDelaySec(wakeDelaySec), .wakeDelayTenth(wakeDelayTenth));
    dfs_bus_master dfs_bus_master_i (.clk(clk), .reqReady(reqReady), .rspValid(rspValid),
        .rsp(rsp), .reqValid(reqValid), .req(req));
    // Counts applied strobes
    always @(posedge clk) begin
        if (cmdStrobe === 1'b1) cmdSeen++;
        if (setpointStrobe === 1'b1) setSeen++;
    end
    // ------------------------------
    // Shared tasks
    // ------------------------------
    task automatic chk(input string n, input logic [15:0] e, g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic x(input logic [7:0] f, input logic [15:0] a, d);
        dfs_bus_master_i.xfer(f, a, d, r);
    endtask
    task automatic err(input logic [7:0] f, e);
        chk("exception", {f | 8'h80, e}, {r.exc ? r.func : 8'h00, r.errCode});
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ------------------------------
    // Tests
    // ------------------------------
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        stat <= {4'hB, mapData[1], mapData[2], mapData[3], mapData[4], mapData[5], mapData[6],
            mapData[7], mapData[8], mapData[9], mapData[10], mapData[12]};
        for (int i = 0; i < 13; i++) begin
            x(8'h03, mapAddr[i], 16'h0000);
            chk("status word", mapData[i], r.data);
            x(8'h06, mapAddr[i], 16'h0007);
            err(8'h06, 8'h07);
            x(8'h03, mapAddr[i], 16'h0000);
            chk("word after write", mapData[i], r.data);
        end
        $display("test status map done");
        x(8'h06, 16'h0001, 16'h0003);
        err(8'h06, 8'h04);
        x(8'h06, 16'h2000, 16'h0001);
        x(8'h06, 16'h0001, 16'h0002);
        x(8'h06, 16'h0002, 16'h0001);
        x(8'h06, 16'h2000, 16'h0001);
        chk("gated commands", 16'h0000, 16'(cmdSeen));
        x(8'h06, 16'h0002, 16'h0000);
        x(8'h06, 16'h2000, 16'h0005);
        chk("command echo", 16'h0005, r.data);
        @(negedge clk);
        chk("command count", 16'h0001, 16'(cmdSeen));
        chk("command code", 16'h0005, cmdCode);
        $display("test command gating done");
        x(8'h06, 16'h2002, 16'hFE0C);
        x(8'h06, 16'h0900, 16'h0007);
        x(8'h06, 16'h2002, 16'hFC18);
        @(negedge clk);
        chk("setpoint count", 16'h0001, 16'(setSeen));
        chk("setpoint", 16'hFC18, setpoint);
        x(8'h06, 16'h2002, 16'h03E9);
        err(8'h06, 8'h04);
        $display("test setpoint done");
        x(8'h06, 16'h0114, 16'h0035);
        @(negedge clk);
        chk("delay units", 16'h0005, wakeDelaySec);
        chk("delay tenths", 16'h0003, {12'h000, wakeDelayTenth});
        x(8'h06, 16'h0114, 16'h8CA1);
        err(8'h06, 8'h04);
        x(8'h03, 16'h0114, 16'h0000);
        chk("delay word", 16'h0035, r.data);
        x(8'h03, 16'h2000, 16'h0000);
        err(8'h03, 8'h02);
        x(8'h10, 16'h300B, 16'h0000);
        err(8'h10, 8'h01);
        $display("test scale and refusals done");
        tally_and_finish();
    end
    // Cuts a hang short
    initial begin
        #100000;
        bad_count++;
        tally_and_finish();
    end
endmodule
